// file: hdl/cssc_divider.sv
// system clock divider, pass-through or divide by eight
`timescale 1ns/100ps
`include "cssc_regs.svh"
module cssc_divider (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic reset_i,
  input  wire logic enable_i,
  // control
  input  wire logic clear_i,
  input  wire logic div8_i,
  // ticks
  input  wire logic tick_i,
  output logic      tick_o
);

  logic [2:0] count;
  logic [2:0] next_count;
  logic       next_tick;

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (clear_i) begin
      next_count = 3'h0;
    end else if (tick_i) begin
      next_count = count + 3'h1;
      next_tick  = !div8_i || (count == `CSSC_DIV8_LAST);
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count  <= 3'h0;
      tick_o <= 1'b0;
    end else if (enable_i) begin
      count  <= next_count;
      tick_o <= next_tick;
    end
  end

endmodule

// file: hdl/cssc_pkg.sv
// types of the clock source and start-up control block
package cssc_pkg;

  // ----------------------------------------
  // oscillator sources
  // ----------------------------------------
  typedef enum logic [2:0] {
    cssc_src_ext      = 3'h0,
    cssc_src_reserved = 3'h1,
    cssc_src_rc_cal   = 3'h2,
    cssc_src_rc_128k  = 3'h3,
    cssc_src_lf_xtal  = 3'h4,
    cssc_src_fs_xtal  = 3'h5,
    cssc_src_lp_xtal  = 3'h6
  } cssc_source_type;

  // ----------------------------------------
  // sleep modes given by the sleep controller
  // ----------------------------------------
  typedef enum logic [2:0] {
    cssc_active       = 3'h0,
    cssc_idle         = 3'h1,
    cssc_adc_quiet    = 3'h2,
    cssc_power_down   = 3'h3,
    cssc_power_save   = 3'h4,
    cssc_standby      = 3'h5,
    cssc_ext_standby  = 3'h6
  } cssc_sleep_type;

  // ----------------------------------------
  // start-up sequencer, gray from hold to halt; halt back to start-up flips two bits
  // ----------------------------------------
  typedef enum logic [2:0] {
    cssc_st_hold      = 3'h0,
    cssc_st_timeout   = 3'h1,
    cssc_st_startup   = 3'h3,
    cssc_st_run       = 3'h2,
    cssc_st_halt      = 3'h6
  } cssc_state_type;

endpackage

// file: hdl/cssc_regs.svh
// constants of the clock source and start-up control block
`ifndef CSSC_REGS_SVH
`define CSSC_REGS_SVH

// ----------------------------------------
// fuse field positions
// ----------------------------------------
`define CSSC_SEL_LOW_BIT   0
`define CSSC_RANGE_MSB     3
`define CSSC_RANGE_LSB     1

// ----------------------------------------
// fuse defaults
// ----------------------------------------
`define CSSC_DEF_SOURCE    4'h2
`define CSSC_DEF_STARTUP   2'h2
`define CSSC_DEF_DIV8      1'h0

// ----------------------------------------
// watchdog-oscillator time-out counts
// ----------------------------------------
`define CSSC_TOUT_NONE     16'h0000
`define CSSC_TOUT_SHORT    16'h0200
`define CSSC_TOUT_LONG     16'h2000

// ----------------------------------------
// oscillator start-up counts
// ----------------------------------------
`define CSSC_START_EXT     16'h0006
`define CSSC_START_258     16'h0102
`define CSSC_START_1K      16'h0400
`define CSSC_START_16K     16'h4000
`define CSSC_START_32K     16'h8000
`define CSSC_EXTRA_14      16'h000e
`define CSSC_EXTRA_4       16'h0004

// ----------------------------------------
// system clock division
// ----------------------------------------
`define CSSC_DIV8_LAST     3'h7

`endif

// file: hdl/cssc_top.sv
// clock source selection, start-up reset sequencing and clock gating
`timescale 1ns/100ps
`include "cssc_regs.svh"
module cssc_top #(
  parameter logic [15:0] LONG_TIMEOUT = `CSSC_TOUT_LONG,
  parameter logic [15:0] XTAL_LONG    = `CSSC_START_16K,
  parameter logic [15:0] LF_LONG      = `CSSC_START_32K
) (
  // clock, reset, enable
  input  wire logic                     clock_i,
  input  wire logic                     reset_i,
  input  wire logic                     enable_i,
  // fuses
  input  wire logic [3:0]               clock_source_select_fuses_i,
  input  wire logic [1:0]               startup_time_fuses_i,
  input  wire logic                     divide_by_eight_fuse_i,
  // reset sources and sleep controller
  input  wire logic                     other_reset_i,
  input  wire cssc_pkg::cssc_sleep_type sleep_mode_i,
  // oscillator ticks
  input  wire logic                     watchdog_tick_i,
  input  wire logic                     lp_xtal_tick_i,
  input  wire logic                     fs_xtal_tick_i,
  input  wire logic                     lf_xtal_tick_i,
  input  wire logic                     rc_128k_tick_i,
  input  wire logic                     rc_cal_tick_i,
  input  wire logic                     ext_clock_tick_i,
  input  wire logic                     async_source_tick_i,
  // reset and clock enables
  output logic                          internal_reset_o,
  output logic                          core_clock_o,
  output logic                          peripheral_clock_o,
  output logic                          program_memory_clock_o,
  output logic                          async_timer_clock_o,
  output logic                          converter_clock_o,
  // asynchronous detector enables
  output logic                          async_int_detect_o,
  output logic                          serial_start_async_o,
  output logic                          two_wire_match_en_o,
  // selection status
  output cssc_pkg::cssc_source_type     source_o,
  output logic [2:0]                    lp_range_o,
  output logic                          source_reserved_o
);
  import cssc_pkg::*;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic cssc_source_type decode_source(input logic [3:0] sel);
    cssc_source_type src;
    src = cssc_src_reserved;
    if (sel[3]) begin
      src = cssc_src_lp_xtal;
    end else if (sel[2:1] == 2'h3) begin
      src = cssc_src_fs_xtal;
    end else if (sel[2:1] == 2'h2) begin
      src = cssc_src_lf_xtal;
    end else if (sel == 4'h3) begin
      src = cssc_src_rc_128k;
    end else if (sel == 4'h2) begin
      src = cssc_src_rc_cal;
    end else if (sel == 4'h0) begin
      src = cssc_src_ext;
    end
    return src;
  endfunction

  // time-out in watchdog cycles
  function automatic logic [15:0] timeout_count(input cssc_source_type src,
                                                input logic sel0,
                                                input logic [1:0] time_code);
    logic [3:0]  code;
    logic [15:0] cnt;
    code = {1'b0, sel0, time_code};
    cnt  = LONG_TIMEOUT;
    if (src == cssc_src_lp_xtal || src == cssc_src_fs_xtal) begin
      case (code)
        4'h0: cnt = `CSSC_TOUT_SHORT;
        4'h1: cnt = LONG_TIMEOUT;
        4'h2: cnt = `CSSC_TOUT_NONE;
        4'h3: cnt = `CSSC_TOUT_SHORT;
        4'h4: cnt = LONG_TIMEOUT;
        4'h5: cnt = `CSSC_TOUT_NONE;
        4'h6: cnt = `CSSC_TOUT_SHORT;
        default: cnt = LONG_TIMEOUT;
      endcase
    end else begin
      case (time_code)
        2'h0: cnt = `CSSC_TOUT_NONE;
        2'h1: cnt = `CSSC_TOUT_SHORT;
        default: cnt = LONG_TIMEOUT;
      endcase
    end
    return cnt;
  endfunction

  // start-up in oscillator cycles; extra cycles only after a reset
  function automatic logic [15:0] startup_count(input cssc_source_type src,
                                                input logic sel0,
                                                input logic [1:0] time_code,
                                                input logic from_reset);
    logic [15:0] base;
    logic [15:0] extra;
    base  = `CSSC_START_EXT;
    extra = `CSSC_EXTRA_14;
    case (src)
      cssc_src_lp_xtal, cssc_src_fs_xtal: begin
        if (!sel0) begin
          base = time_code[1] ? `CSSC_START_1K : `CSSC_START_258;
        end else begin
          base = (time_code == 2'h0) ? `CSSC_START_1K : XTAL_LONG;
        end
      end
      cssc_src_lf_xtal: begin
        base  = sel0 ? LF_LONG : `CSSC_START_1K;
        extra = `CSSC_EXTRA_4;
      end
      default: begin
        base = `CSSC_START_EXT;
      end
    endcase
    return from_reset ? base + extra : base;
  endfunction

  // ----------------------------------------
  // fuse capture
  // ----------------------------------------
  logic [3:0] sel_fuse;
  logic [1:0] time_fuse;
  logic       div8_fuse;
  logic [3:0] next_sel_fuse;
  logic [1:0] next_time_fuse;
  logic       next_div8_fuse;

  cssc_state_type state;
  cssc_state_type next_state;

  always_comb begin
    next_sel_fuse  = sel_fuse;
    next_time_fuse = time_fuse;
    next_div8_fuse = div8_fuse;
    if (state == cssc_st_hold) begin
      next_sel_fuse  = clock_source_select_fuses_i;
      next_time_fuse = startup_time_fuses_i;
      next_div8_fuse = divide_by_eight_fuse_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sel_fuse  <= `CSSC_DEF_SOURCE;
      time_fuse <= `CSSC_DEF_STARTUP;
      div8_fuse <= `CSSC_DEF_DIV8;
    end else if (enable_i) begin
      sel_fuse  <= next_sel_fuse;
      time_fuse <= next_time_fuse;
      div8_fuse <= next_div8_fuse;
    end
  end

  // ----------------------------------------
  // source selection
  // ----------------------------------------
  cssc_source_type src;
  logic            src_tick;
  logic [15:0]     tout_target;
  logic [15:0]     start_target;
  logic            from_reset;

  always_comb begin
    src = decode_source(sel_fuse);
    case (src)
      cssc_src_lp_xtal: src_tick = lp_xtal_tick_i;
      cssc_src_fs_xtal: src_tick = fs_xtal_tick_i;
      cssc_src_lf_xtal: src_tick = lf_xtal_tick_i;
      cssc_src_rc_128k: src_tick = rc_128k_tick_i;
      cssc_src_rc_cal:  src_tick = rc_cal_tick_i;
      cssc_src_ext:     src_tick = ext_clock_tick_i;
      default:          src_tick = 1'b0;
    endcase
    tout_target  = timeout_count(src, sel_fuse[`CSSC_SEL_LOW_BIT], time_fuse);
    start_target = startup_count(src, sel_fuse[`CSSC_SEL_LOW_BIT], time_fuse,
                                 from_reset);
  end

  // ----------------------------------------
  // start-up sequencer
  // ----------------------------------------
  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_from_reset;
  logic        deep_sleep;

  assign deep_sleep = (sleep_mode_i == cssc_power_down) ||
                      (sleep_mode_i == cssc_power_save);

  always_comb begin
    next_state      = state;
    next_count      = count;
    next_from_reset = from_reset;
    case (state)
      cssc_st_hold: begin
        next_count      = 16'h0000;
        next_from_reset = 1'b1;
        if (!other_reset_i) begin
          next_state = cssc_st_timeout;
        end
      end
      cssc_st_timeout: begin
        if (count >= tout_target) begin
          next_state = cssc_st_startup;
          next_count = 16'h0000;
        end else if (watchdog_tick_i) begin
          next_count = count + 16'h0001;
        end
      end
      cssc_st_startup: begin
        if (count >= start_target) begin
          next_state = cssc_st_run;
          next_count = 16'h0000;
        end else if (src_tick) begin
          next_count = count + 16'h0001;
        end
      end
      cssc_st_run: begin
        if (deep_sleep) begin
          next_state      = cssc_st_halt;
          next_from_reset = 1'b0;
        end
      end
      cssc_st_halt: begin
        next_count = 16'h0000;
        if (!deep_sleep) begin
          next_state = cssc_st_startup;
        end
      end
      default: begin
        next_state = cssc_st_hold;
      end
    endcase
    if (other_reset_i) begin
      next_state = cssc_st_hold;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state      <= cssc_st_hold;
      count      <= 16'h0000;
      from_reset <= 1'b1;
    end else if (enable_i) begin
      state      <= next_state;
      count      <= next_count;
      from_reset <= next_from_reset;
    end
  end

  // ----------------------------------------
  // system clock division
  // ----------------------------------------
  logic sys_tick;

  cssc_divider u_divider (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .enable_i (enable_i),
    .clear_i  (state != cssc_st_run),
    .div8_i   (!div8_fuse),
    .tick_i   (src_tick),
    .tick_o   (sys_tick)
  );

  // ----------------------------------------
  // clock gating per sleep mode
  // ----------------------------------------
  // gates follow the sequencer so only the async timer sees ticks under internal reset, from the time-out state on
  logic running;
  logic core_run;
  logic io_run;
  logic adc_run;
  logic asy_run;
  logic next_reset;
  logic next_core;
  logic next_io;
  logic next_asy;
  logic next_adc;

  always_comb begin
    running    = (state == cssc_st_run);
    core_run   = running && (sleep_mode_i == cssc_active);
    io_run     = running && (sleep_mode_i == cssc_active ||
                             sleep_mode_i == cssc_idle);
    adc_run    = io_run || (running && sleep_mode_i == cssc_adc_quiet);
    asy_run    = (state != cssc_st_hold) &&
                 (sleep_mode_i != cssc_power_down) &&
                 (sleep_mode_i != cssc_standby);
    next_reset = !running && !(state == cssc_st_halt && !from_reset);
    next_core  = sys_tick && core_run;
    next_io    = sys_tick && io_run;
    next_adc   = sys_tick && adc_run;
    next_asy   = async_source_tick_i && asy_run;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      internal_reset_o       <= 1'b1;
      core_clock_o           <= 1'b0;
      program_memory_clock_o <= 1'b0;
      peripheral_clock_o     <= 1'b0;
      converter_clock_o      <= 1'b0;
      async_timer_clock_o    <= 1'b0;
      async_int_detect_o     <= 1'b1;
      serial_start_async_o   <= 1'b1;
      two_wire_match_en_o    <= 1'b1;
      source_o               <= cssc_src_rc_cal;
      lp_range_o             <= 3'h0;
      source_reserved_o      <= 1'b0;
    end else if (enable_i) begin
      internal_reset_o       <= next_reset;
      core_clock_o           <= next_core;
      program_memory_clock_o <= next_core;
      peripheral_clock_o     <= next_io;
      converter_clock_o      <= next_adc;
      async_timer_clock_o    <= next_asy;
      async_int_detect_o     <= !io_run;
      serial_start_async_o   <= !io_run;
      two_wire_match_en_o    <= 1'b1;
      source_o               <= src;
      lp_range_o             <= (src == cssc_src_lp_xtal) ?
                                sel_fuse[`CSSC_RANGE_MSB:`CSSC_RANGE_LSB] :
                                3'h0;
      source_reserved_o      <= (src == cssc_src_reserved);
    end
  end

endmodule

// file: verification/cssc_bench.sv
// self-checking bench for the clock source and start-up block
`timescale 1ns/100ps
module cssc_bench;
  import cssc_pkg::*;
  // ----------
  // signals
  // ----------
  typedef struct {
    logic [3:0]      fuse;
    logic [1:0]      start_time;
    cssc_source_type src;
    logic [2:0]      range;
    int              cycles;
  } cssc_row_type;
  // cycles = timeout + start count + 4, with the shortened long counts 16/20/24
  cssc_row_type rows [13] = '{
    '{4'hf, 2'h3, cssc_src_lp_xtal, 3'h7, 54}, '{4'h8, 2'h0, cssc_src_lp_xtal, 3'h4, 788},
    '{4'hc, 2'h1, cssc_src_lp_xtal, 3'h6, 292}, '{4'ha, 2'h2, cssc_src_lp_xtal, 3'h5, 1042},
    '{4'h6, 2'h3, cssc_src_fs_xtal, 3'h0, 1554}, '{4'hb, 2'h0, cssc_src_lp_xtal, 3'h5, 1058},
    '{4'h9, 2'h1, cssc_src_lp_xtal, 3'h4, 38}, '{4'h7, 2'h2, cssc_src_fs_xtal, 3'h0, 550},
    '{4'h5, 2'h0, cssc_src_lf_xtal, 3'h0, 32}, '{4'h4, 2'h1, cssc_src_lf_xtal, 3'h0, 1544},
    '{4'h3, 2'h2, cssc_src_rc_128k, 3'h0, 40}, '{4'h0, 2'h3, cssc_src_ext, 3'h0, 40},
    '{4'h2, 2'h0, cssc_src_rc_cal, 3'h0, 24}};
  // mode in bits 6:4, then core, peripheral, converter, async timer
  logic [6:0] modes [7] = '{7'h0f, 7'h17, 7'h23, 7'h50, 7'h61, 7'h41, 7'h30};
  logic clock_i = 1'h0;
  logic reset_i = 1'h1;
  logic enable_i = 1'h1;
  logic [3:0] fuses = 4'h2;
  logic [1:0] start_time = 2'h2;
  logic div8 = 1'h1;
  logic other_reset_i = 1'h1;
  cssc_sleep_type sleep_mode_i = cssc_active;
  logic [6:0] osc_enable = 7'h04;
  logic watchdog_tick_i, async_source_tick_i, internal_reset_o, core_clock_o;
  logic peripheral_clock_o, program_memory_clock_o, async_timer_clock_o, converter_clock_o;
  logic async_int_detect_o, serial_start_async_o, two_wire_match_en_o, source_reserved_o;
  logic [6:0] tk;
  logic [2:0] lp_range_o;
  cssc_source_type source_o;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  cssc_osc_model u_cssc_osc_model (.clock_i, .osc_enable_i(osc_enable),
    .watchdog_tick_o(watchdog_tick_i), .osc_tick_o(tk), .async_tick_o(async_source_tick_i));
  cssc_top #(.LONG_TIMEOUT(16'h0010), .XTAL_LONG(16'h0014), .LF_LONG(16'h0018)) u_cssc_top (
    .clock_i, .reset_i, .enable_i, .clock_source_select_fuses_i(fuses),
    .startup_time_fuses_i(start_time), .divide_by_eight_fuse_i(div8), .other_reset_i,
    .sleep_mode_i,
    .watchdog_tick_i, .lp_xtal_tick_i(tk[6]), .fs_xtal_tick_i(tk[5]), .lf_xtal_tick_i(tk[4]),
    .rc_128k_tick_i(tk[3]), .rc_cal_tick_i(tk[2]), .ext_clock_tick_i(tk[0]),
    .async_source_tick_i, .internal_reset_o, .core_clock_o, .peripheral_clock_o,
    .program_memory_clock_o, .async_timer_clock_o, .converter_clock_o, .async_int_detect_o,
    .serial_start_async_o, .two_wire_match_en_o, .source_o, .lp_range_o, .source_reserved_o);
  // ----------
  // tasks
  // ----------
  always #12.5 clock_i = ~clock_i;
  task automatic step(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  // fuses change only while held in reset; count edges until the reset drops
  task automatic start(input logic [3:0] f, input logic [1:0] s, input logic [6:0] m,
                       output int c);
    other_reset_i = 1'h1;
    fuses = f;
    start_time = s;
    osc_enable = m;
    step(3);
    check(internal_reset_o, 1'h1);
    other_reset_i = 1'h0;
    c = 0;
    do begin
      step(1);
      c++;
    end while (internal_reset_o !== 1'h0 && c < 3000);
  endtask
  task automatic close_out();
    $display("mismatches %0d of %0d checks", fails, check_count);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // run is about 10300 cycles, so this ceiling only trips on a hang
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  // ----------
  // sequence
  // ----------
  initial begin
    step(11);
    check({internal_reset_o, core_clock_o, async_int_detect_o, two_wire_match_en_o, source_o,
           lp_range_o, source_reserved_o}, {4'hb, 3'h2, 3'h0, 1'h0});
    step(1);
    reset_i = 1'h0;
    foreach (rows[i]) begin
      start(rows[i].fuse, rows[i].start_time, 7'h01 << rows[i].src, n);
      check(16'(n), 16'(rows[i].cycles));
      check(source_o, rows[i].src);
      check(lp_range_o, rows[i].range);
    end
    foreach (modes[i]) begin
      sleep_mode_i = cssc_sleep_type'(modes[i][6:4]);
      step(4);
      check({core_clock_o, peripheral_clock_o, converter_clock_o, async_timer_clock_o},
            modes[i][3:0]);
      check(async_int_detect_o, !modes[i][2]);
      check(serial_start_async_o, !modes[i][2]);
      check(program_memory_clock_o, modes[i][3]);
    end
    check(internal_reset_o, 1'h0);
    // enable low for five edges mid start-up stretches the wake count by five
    sleep_mode_i = cssc_active;
    n = 0;
    for (int k = 0; k < 40; k++) begin
      enable_i = !(k inside {[4:8]});
      step(1);
      n += internal_reset_o;
    end
    check(16'(n), 16'h000c);
    div8 = 1'h0;
    start(4'h2, 2'h0, 7'h04, n);
    n = 0;
    repeat (80) begin
      step(1);
      n += core_clock_o;
    end
    check(16'(n), 16'h000a);
    fuses = 4'hf;
    step(5);
    check({source_o, lp_range_o}, {3'h2, 3'h0});
    start(4'h1, 2'h0, 7'h7f, n);
    check(16'(n), 16'h0bb8);
    check(source_reserved_o, 1'h1);
    reset_i = 1'h1;
    step(3);
    check(source_reserved_o, 1'h0);
    close_out();
  end
endmodule
bind cssc_top cssc_checker #(.LONG_TIMEOUT(LONG_TIMEOUT), .XTAL_LONG(XTAL_LONG),
  .LF_LONG(LF_LONG)) u_cssc_checker (.clock_i, .reset_i, .sleep_mode_i, .other_reset_i,
  .async_source_tick_i, .internal_reset_o, .core_clock_o, .peripheral_clock_o,
  .program_memory_clock_o, .async_timer_clock_o, .converter_clock_o, .async_int_detect_o,
  .serial_start_async_o, .two_wire_match_en_o, .source_o, .lp_range_o, .source_reserved_o);

// file: verification/cssc_checker.sv
// assertion checker on the ports of the clock block
`timescale 1ns/100ps
module cssc_checker #(
  parameter logic [15:0] LONG_TIMEOUT = 16'h2000,
  parameter logic [15:0] XTAL_LONG    = 16'h4000,
  parameter logic [15:0] LF_LONG      = 16'h8000
) (
  // clock and reset
  input wire logic                     clock_i,
  input wire logic                     reset_i,
  // stimulus
  input wire cssc_pkg::cssc_sleep_type sleep_mode_i,
  input wire logic                     other_reset_i,
  input wire logic                     async_source_tick_i,
  // outputs
  input wire logic                     internal_reset_o,
  input wire logic                     core_clock_o,
  input wire logic                     peripheral_clock_o,
  input wire logic                     program_memory_clock_o,
  input wire logic                     async_timer_clock_o,
  input wire logic                     converter_clock_o,
  input wire logic                     async_int_detect_o,
  input wire logic                     serial_start_async_o,
  input wire logic                     two_wire_match_en_o,
  input wire cssc_pkg::cssc_source_type source_o,
  input wire logic [2:0]               lp_range_o,
  input wire logic                     source_reserved_o
);
  import cssc_pkg::*;
  // ----------
  // assertions
  // ----------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  a_reset_values: assert property ($fell(reset_i) |-> internal_reset_o && !core_clock_o
    && source_o == cssc_src_rc_cal && lp_range_o == 3'h0 && two_wire_match_en_o)
    else $error("outputs wrong after reset");
  a_flash_core: assert property (program_memory_clock_o == core_clock_o)
    else $error("program memory clock differs from core clock");
  a_core_active: assert property (core_clock_o |-> $past(sleep_mode_i) == cssc_active)
    else $error("core clock outside active mode");
  a_periph_modes: assert property (peripheral_clock_o |->
    $past(sleep_mode_i) inside {cssc_active, cssc_idle})
    else $error("peripheral clock in wrong mode");
  a_conv_modes: assert property (converter_clock_o |->
    $past(sleep_mode_i) inside {cssc_active, cssc_idle, cssc_adc_quiet})
    else $error("converter clock in wrong mode");
  a_async_follow: assert property (async_source_tick_i && !internal_reset_o && !other_reset_i
    && sleep_mode_i == cssc_active |=> async_timer_clock_o)
    else $error("async timer tick lost");
  a_async_gate: assert property (sleep_mode_i == cssc_power_down [*2] |=> !async_timer_clock_o)
    else $error("async timer runs in power down");
  a_serial_async: assert property (serial_start_async_o == async_int_detect_o
    && two_wire_match_en_o)
    else $error("async detector enables wrong");
  a_reserved_hold: assert property (source_reserved_o |-> internal_reset_o)
    else $error("reserved source released reset");
  a_fuse_hold: assert property (!internal_reset_o && !$past(internal_reset_o) |->
    $stable(source_o) && $stable(lp_range_o))
    else $error("selection changed while running");
  cover property ($fell(internal_reset_o));
  cover property (source_reserved_o);
  cover property (sleep_mode_i == cssc_power_down && !internal_reset_o);
endmodule

// file: verification/cssc_osc_model.sv
// oscillator and watchdog tick model for the clock block bench
`timescale 1ns/100ps
module cssc_osc_model (
  // clock
  input  wire logic       clock_i,
  // oscillators the bench has running
  input  wire logic [6:0] osc_enable_i,
  // ticks
  output logic            watchdog_tick_o,
  output logic [6:0]      osc_tick_o,
  output logic            async_tick_o
);
  // ----------
  // ticks
  // ----------
  // one tick per cycle is the fastest legal rate, worst case for the counters
  // fitted part is a ceramic resonator, so the lowest range and short start are fair
  always_ff @(posedge clock_i) begin
    watchdog_tick_o <= 1'h1;
    osc_tick_o      <= osc_enable_i;
    async_tick_o    <= 1'h1;
  end
endmodule
